// file: hw/ucsr_bank.sv
// uart fifo control mirrors and uart 3/4 miscellaneous config registers
// What this block does
// - registers reachable only in config state with their own index loaded
// - uart1 mirror shows bits 7:6, 3 and 0 of last value written to uart1 fifo control
// - index 16h mirrors uart2 fifo control, same layout
// - index 19h mirrors uart3 fifo control, config state only
// - bit 0 enables both transmit and receive fifos
// - bit 1 flushes receive fifo and counters, then self-clears
// - bit 2 flushes transmit fifo and counters, then self-clears
// - bit 3 dma select stored but has no effect
// - bits 7:6 pick receive threshold 1, 4, 8 or 14 bytes
// - misc bit 4 enables midi clocking for port 3
// - misc bit 5 enables midi clocking for port 4
// - misc bit 6 selects high speed for uart3
// - misc bit 7 selects high speed for uart4
// - misc clears on power-on; speed bits also clear on hard reset
// - midi clocking gives 31.25 kbaud within one percent
// - reserved index 17h reads 03h after power-up
`timescale 1ns/1ps
`include "ucsr_consts.svh"

module ucsr_bank
#(
	parameter logic [15:0] MIDI_DIVISOR = 16'(`UCSR_MIDI_CYCLES)
)
(
	// clock and resets
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       hard_reset,
	// configuration port
	input  wire logic       cfg_state,
	input  wire logic [7:0] config_index_register,
	input  wire logic       cfg_wr,
	input  wire logic       cfg_rd,
	input  wire logic [7:0] cfg_wdata,
	output logic      [7:0] cfg_rdata,
	output logic            cfg_hit,
	// runtime fifo control writes, one strobe per uart
	input  wire logic       u1_fcr_we,
	input  wire logic       u2_fcr_we,
	input  wire logic       u3_fcr_we,
	input  wire logic [7:0] fcr_wdata,
	// uart1 fifo controls
	output logic            u1_fifo_enable,
	output logic            u1_rx_flush,
	output logic            u1_tx_flush,
	output logic      [3:0] u1_rx_threshold_sel,
	// uart2 fifo controls
	output logic            u2_fifo_enable,
	output logic            u2_rx_flush,
	output logic            u2_tx_flush,
	output logic      [3:0] u2_rx_threshold_sel,
	// uart3 fifo controls
	output logic            u3_fifo_enable,
	output logic            u3_rx_flush,
	output logic            u3_tx_flush,
	output logic      [3:0] u3_rx_threshold_sel,
	// uart3/4 clocking
	output logic            port3_midi_clock_sel,
	output logic            port4_midi_clock_sel,
	output logic            u3_high_speed,
	output logic            u4_high_speed,
	output logic            port3_midi_tick,
	output logic            port4_midi_tick
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	ucsr_pkg::ucsr_state_t st;
	ucsr_pkg::ucsr_state_t next_st;
	logic [7:0]            m1;
	logic [7:0]            m2;
	logic [7:0]            m3;

	function automatic logic idx_hit(input logic [7:0] idx,
		input logic [7:0] want);
		idx_hit = (idx == want);
	endfunction

	// ------------------------------------------------------------------
	// fifo control capture per uart
	// ------------------------------------------------------------------
	// mirrors load only from runtime writes, never from config
	ucsr_fcr_capture u_fcr1
	(
		.clk_sys          (clk_sys),
		.rst_n            (rst_n),
		.fcr_we           (u1_fcr_we),
		.fcr_wdata        (fcr_wdata),
		.mirror           (m1),
		.fifo_enable      (u1_fifo_enable),
		.rx_flush         (u1_rx_flush),
		.tx_flush         (u1_tx_flush),
		.rx_threshold_sel (u1_rx_threshold_sel)
	);

	ucsr_fcr_capture u_fcr2
	(
		.clk_sys          (clk_sys),
		.rst_n            (rst_n),
		.fcr_we           (u2_fcr_we),
		.fcr_wdata        (fcr_wdata),
		.mirror           (m2),
		.fifo_enable      (u2_fifo_enable),
		.rx_flush         (u2_rx_flush),
		.tx_flush         (u2_tx_flush),
		.rx_threshold_sel (u2_rx_threshold_sel)
	);

	ucsr_fcr_capture u_fcr3
	(
		.clk_sys          (clk_sys),
		.rst_n            (rst_n),
		.fcr_we           (u3_fcr_we),
		.fcr_wdata        (fcr_wdata),
		.mirror           (m3),
		.fifo_enable      (u3_fifo_enable),
		.rx_flush         (u3_rx_flush),
		.tx_flush         (u3_tx_flush),
		.rx_threshold_sel (u3_rx_threshold_sel)
	);

	// ------------------------------------------------------------------
	// config access and register update
	// ------------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		next_st.mirror1 = m1;
		next_st.mirror2 = m2;
		next_st.mirror3 = m3;
		next_st.rdata = `UCSR_ZERO_BYTE;
		// only the misc register takes config writes
		if (cfg_state && cfg_wr
			&& idx_hit(config_index_register, `UCSR_IDX_MISC))
			next_st.misc = cfg_wdata & `UCSR_MISC_MASK;
		// hard reset clears speed bits, midi selects survive
		if (hard_reset)
			next_st.misc = next_st.misc & `UCSR_MISC_SPEED_CLR;
		if (cfg_state && cfg_rd)
		begin
			case (config_index_register)
				`UCSR_IDX_U1_MIRROR: next_st.rdata = m1;
				`UCSR_IDX_U2_MIRROR: next_st.rdata = m2;
				`UCSR_IDX_RSVD17:    next_st.rdata = st.rsvd17;
				`UCSR_IDX_MISC:      next_st.rdata = st.misc;
				`UCSR_IDX_U3_MIRROR: next_st.rdata = m3;
				default:             next_st.rdata = `UCSR_ZERO_BYTE;
			endcase
		end
	end

	// rst_n stands for the power-on reset of the whole bank
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.misc <= `UCSR_MISC_RESET;
			st.rsvd17 <= `UCSR_RSVD17_RESET;
		end
		else
			st <= next_st;
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign cfg_rdata = st.rdata;
	// hit covers the five indices, only in config state
	assign cfg_hit = cfg_state
		&& (config_index_register >= `UCSR_IDX_U1_MIRROR)
		&& (config_index_register <= `UCSR_IDX_U3_MIRROR);
	assign port3_midi_clock_sel = st.misc[`UCSR_MISC_MIDI3_BIT];
	assign port4_midi_clock_sel = st.misc[`UCSR_MISC_MIDI4_BIT];
	assign u3_high_speed = st.misc[`UCSR_MISC_HS3_BIT];
	assign u4_high_speed = st.misc[`UCSR_MISC_HS4_BIT];

	// ------------------------------------------------------------------
	// midi bit clocks
	// ------------------------------------------------------------------
	ucsr_midi_tick #(.DIVISOR(MIDI_DIVISOR)) u_midi3
	(
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.enable  (port3_midi_clock_sel),
		.tick    (port3_midi_tick)
	);

	ucsr_midi_tick #(.DIVISOR(MIDI_DIVISOR)) u_midi4
	(
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.enable  (port4_midi_clock_sel),
		.tick    (port4_midi_tick)
	);

endmodule

// file: hw/ucsr_fcr_capture.sv
// captures one uart's write-only fifo control byte and its flush pulses
`timescale 1ns/1ps
`include "ucsr_consts.svh"

module ucsr_fcr_capture
(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// runtime fifo control write
	input  wire logic       fcr_we,
	input  wire logic [7:0] fcr_wdata,
	// uart side
	output logic      [7:0] mirror,
	output logic            fifo_enable,
	output logic            rx_flush,
	output logic            tx_flush,
	output logic      [3:0] rx_threshold_sel
);

	ucsr_pkg::ucsr_fcr_state_t st;
	ucsr_pkg::ucsr_fcr_state_t next_st;

	function automatic logic [3:0] trig_bytes(input logic [1:0] sel);
		case (sel)
			2'h0:    trig_bytes = `UCSR_TRIG_LVL0;
			2'h1:    trig_bytes = `UCSR_TRIG_LVL1;
			2'h2:    trig_bytes = `UCSR_TRIG_LVL2;
			default: trig_bytes = `UCSR_TRIG_LVL3;
		endcase
	endfunction

	always_comb
	begin
		next_st = st;
		next_st.rx_flush = 1'b0;
		next_st.tx_flush = 1'b0;
		if (fcr_we)
		begin
			// reset bits self-clear; reserved 4,5 never stored
			next_st.fcr = fcr_wdata & `UCSR_FCR_STORE_MASK;
			next_st.rx_flush = fcr_wdata[`UCSR_FCR_RXRST_BIT];
			next_st.tx_flush = fcr_wdata[`UCSR_FCR_TXRST_BIT];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign mirror = st.fcr;
	assign fifo_enable = st.fcr[`UCSR_FCR_EN_BIT];
	assign rx_flush = st.rx_flush;
	assign tx_flush = st.tx_flush;
	// dma bit is stored only, nothing downstream reads it
	assign rx_threshold_sel = trig_bytes(
		st.fcr[`UCSR_FCR_TRIG_HI:`UCSR_FCR_TRIG_LO]);

endmodule

// file: hw/ucsr_midi_tick.sv
// 31.25 kbaud bit tick for a port running midi clocking
`timescale 1ns/1ps
`include "ucsr_consts.svh"

module ucsr_midi_tick
#(
	parameter logic [15:0] DIVISOR = 16'(`UCSR_MIDI_CYCLES)
)
(
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// control
	input  wire logic enable,
	// bit tick
	output logic      tick
);

	ucsr_pkg::ucsr_midi_state_t st;
	ucsr_pkg::ucsr_midi_state_t next_st;

	// exact division at 200 MHz, so well inside the one percent window
	always_comb
	begin
		next_st = st;
		next_st.tick = 1'b0;
		if (!enable)
			next_st.count = '0;
		else if (st.count == DIVISOR - 16'h0001)
		begin
			next_st.count = '0;
			next_st.tick = 1'b1;
		end
		else
			next_st.count = st.count + 16'h0001;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign tick = st.tick;

endmodule

// file: inc/ucsr_consts.svh
// offsets, field positions, reset values and timing figures of the bank
`ifndef UCSR_CONSTS_SVH
`define UCSR_CONSTS_SVH

// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define UCSR_IDX_U1_MIRROR  8'h15
`define UCSR_IDX_U2_MIRROR  8'h16
`define UCSR_IDX_RSVD17     8'h17
`define UCSR_IDX_MISC       8'h18
`define UCSR_IDX_U3_MIRROR  8'h19

// ----------------------------------------------------------------------
// reset values and field layout
// ----------------------------------------------------------------------
`define UCSR_RSVD17_RESET   8'h03
`define UCSR_MISC_RESET     8'h00
`define UCSR_ZERO_BYTE      8'h00
`define UCSR_FCR_STORE_MASK 8'hc9
`define UCSR_MISC_MASK      8'hf0
`define UCSR_MISC_SPEED_CLR 8'h3f
`define UCSR_FCR_EN_BIT     0
`define UCSR_FCR_RXRST_BIT  1
`define UCSR_FCR_TXRST_BIT  2
`define UCSR_FCR_DMA_BIT    3
`define UCSR_FCR_TRIG_HI    7
`define UCSR_FCR_TRIG_LO    6
`define UCSR_MISC_MIDI3_BIT 4
`define UCSR_MISC_MIDI4_BIT 5
`define UCSR_MISC_HS3_BIT   6
`define UCSR_MISC_HS4_BIT   7

// ----------------------------------------------------------------------
// receive thresholds in bytes
// ----------------------------------------------------------------------
`define UCSR_TRIG_LVL0      4'h1
`define UCSR_TRIG_LVL1      4'h4
`define UCSR_TRIG_LVL2      4'h8
`define UCSR_TRIG_LVL3      4'he

// ----------------------------------------------------------------------
// midi bit timing
// ----------------------------------------------------------------------
`define UCSR_CLK_HZ         200000000
`define UCSR_MIDI_BAUD      31250
`define UCSR_MIDI_CYCLES    (`UCSR_CLK_HZ / `UCSR_MIDI_BAUD)

`endif

// file: inc/ucsr_pkg.sv
// types of the uart configuration shadow bank
package ucsr_pkg;

	typedef struct packed {
		logic [7:0] mirror1;
		logic [7:0] mirror2;
		logic [7:0] mirror3;
		logic [7:0] misc;
		logic [7:0] rsvd17;
		logic [7:0] rdata;
	} ucsr_state_t;

	typedef struct packed {
		logic [7:0] fcr;
		logic       rx_flush;
		logic       tx_flush;
	} ucsr_fcr_state_t;

	typedef struct packed {
		logic [15:0] count;
		logic        tick;
	} ucsr_midi_state_t;

endpackage

// file: verification/ucsr_bank_bench.sv
// self-checking bench of the uart config shadow bank
`timescale 1ns/1ps

module ucsr_bank_bench;
	// ------
	// stimulus and design outputs
	// ------
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        hard_reset = 1'b0;
	logic        cfg_state = 1'b0;
	logic [7:0]  config_index_register = 8'h00;
	logic        cfg_wr = 1'b0;
	logic        cfg_rd = 1'b0;
	logic [7:0]  cfg_wdata = 8'h00;
	logic        u1_fcr_we = 1'b0;
	logic        u2_fcr_we = 1'b0;
	logic        u3_fcr_we = 1'b0;
	logic [7:0]  fcr_wdata = 8'h00;
	wire  [7:0]  cfg_rdata;
	wire         cfg_hit, u1_fifo_enable, u1_rx_flush, u1_tx_flush;
	wire         u2_fifo_enable, u2_rx_flush, u2_tx_flush;
	wire         u3_fifo_enable, u3_rx_flush, u3_tx_flush;
	wire  [3:0]  u1_rx_threshold_sel, u2_rx_threshold_sel;
	wire  [3:0]  u3_rx_threshold_sel;
	wire         port3_midi_clock_sel, port4_midi_clock_sel;
	wire         u3_high_speed, u4_high_speed;
	wire         port3_midi_tick, port4_midi_tick;
	wire  [2:0]  en_v = {u3_fifo_enable, u2_fifo_enable, u1_fifo_enable};
	wire  [2:0]  rxf_v = {u3_rx_flush, u2_rx_flush, u1_rx_flush};
	wire  [2:0]  txf_v = {u3_tx_flush, u2_tx_flush, u1_tx_flush};
	wire  [11:0] thr_v = {u3_rx_threshold_sel, u2_rx_threshold_sel,
		u1_rx_threshold_sel};
	wire  [3:0]  misc_v = {u4_high_speed, u3_high_speed,
		port4_midi_clock_sel, port3_midi_clock_sel};
	logic [7:0]  exp_q [$];
	logic [7:0]  idx [3] = '{8'h15, 8'h16, 8'h19};
	logic [3:0]  lvl [4] = '{4'h1, 4'h4, 4'h8, 4'he};
	logic        rd_d = 1'b0;
	logic [7:0]  d, n3, n4;
	int          n_mismatch = 0;
	int          comparisons = 0;

	// small divisor keeps the midi period short
	ucsr_bank #(.MIDI_DIVISOR(16'h0008)) dut (.*);

	always #2.5 clk_sys = ~clk_sys;

	// ------
	// tasks
	// ------
	task check(input string n, input logic [15:0] got, exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", n, exp, got);
		end
	endtask

	task cfg_write(input logic [7:0] i, v, input logic st);
		@(posedge clk_sys);
		cfg_state <= st;
		config_index_register <= i;
		cfg_wdata <= v;
		cfg_wr <= 1'b1;
		@(posedge clk_sys);
		cfg_wr <= 1'b0;
	endtask

	task cfg_read(input logic [7:0] i, v, input logic st);
		@(posedge clk_sys);
		cfg_state <= st;
		config_index_register <= i;
		cfg_rd <= 1'b1;
		exp_q.push_back(v);
		@(posedge clk_sys);
		cfg_rd <= 1'b0;
	endtask

	task fcr_write(input int u, input logic [7:0] v);
		@(posedge clk_sys);
		fcr_wdata <= v;
		u1_fcr_we <= u == 0;
		u2_fcr_we <= u == 1;
		u3_fcr_we <= u == 2;
		@(posedge clk_sys);
		{u3_fcr_we, u2_fcr_we, u1_fcr_we} <= 3'h0;
	endtask

	task stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ------
	// read data monitor
	// ------
	always @(posedge clk_sys)
	begin
		if (rd_d)
			check("cfg_rdata", cfg_rdata, exp_q.pop_front());
		rd_d <= cfg_rd;
	end

	// whole run is well under a thousand cycles
	initial
	begin
		#10000;
		n_mismatch++;
		stop_test;
	end

	initial
	begin
		void'($urandom(32'hee0705a1));
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		cfg_read(8'h17, 8'h03, 1'b1);
		cfg_read(8'h18, 8'h00, 1'b1);
		cfg_read(8'h17, 8'h00, 1'b0);
		$display("test reset_values done");
		for (int u = 0; u < 3; u++)
			for (int c = 0; c < 4; c++)
			begin
				// bits 2:1 follow c so both flush pulses are exercised
				d = {2'(c), 3'($urandom()), 2'(c), 1'($urandom())};
				fcr_write(u, d);
				#1;
				check("fifo_enable", en_v[u], d[0]);
				check("rx_flush", rxf_v, 3'(d[1]) << u);
				check("tx_flush", txf_v, 3'(d[2]) << u);
				check("threshold", thr_v[u*4+:4], lvl[c]);
				@(posedge clk_sys);
				#1;
				check("flush_end", {rxf_v, txf_v}, 6'h00);
				cfg_write(idx[u], ~d, 1'b1);
				cfg_read(idx[u], d & 8'hc9, 1'b1);
			end
		$display("test fifo_mirrors done");
		repeat (4)
		begin
			d = 8'($urandom());
			cfg_write(8'h18, d, 1'b1);
			#1 check("misc", misc_v, d[7:4]);
			cfg_read(8'h18, d & 8'hf0, 1'b1);
		end
		cfg_write(8'h18, 8'hf0, 1'b1);
		cfg_write(8'h18, 8'h00, 1'b0);
		#1 check("misc_locked", misc_v, 4'hf);
		// hard reset stays up across a misc write: speed bits must lose
		@(posedge clk_sys);
		hard_reset <= 1'b1;
		cfg_write(8'h18, 8'hf0, 1'b1);
		hard_reset <= 1'b0;
		#1 check("misc_hard", misc_v, 4'h3);
		$display("test misc done");
		n3 = 8'h00;
		n4 = 8'h00;
		repeat (80)
		begin
			@(posedge clk_sys);
			n3 = n3 + 8'(port3_midi_tick);
			n4 = n4 + 8'(port4_midi_tick);
		end
		check("midi3_ticks", n3, 8'h0a);
		check("midi4_ticks", n4, 8'h0a);
		$display("test midi done");
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		cfg_read(8'h18, 8'h00, 1'b1);
		cfg_read(8'h17, 8'h03, 1'b1);
		repeat (3) @(posedge clk_sys);
		$display("test second_reset done");
		stop_test;
	end
endmodule

// file: verification/ucsr_bank_chk.sv
// assertion checker of the uart config shadow bank
`timescale 1ns/1ps

module ucsr_bank_chk
#(
	parameter logic [15:0] MIDI_DIVISOR = 16'h1900
)
(
	// clock and resets
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        hard_reset,
	// configuration port
	input wire logic        cfg_state,
	input wire logic [7:0]  config_index_register,
	input wire logic        cfg_wr,
	input wire logic        cfg_rd,
	input wire logic [7:0]  cfg_wdata,
	input wire logic [7:0]  cfg_rdata,
	input wire logic        cfg_hit,
	// fifo control
	input wire logic        u1_fcr_we,
	input wire logic        u2_fcr_we,
	input wire logic        u3_fcr_we,
	input wire logic [7:0]  fcr_wdata,
	input wire logic        u1_fifo_enable,
	input wire logic        u1_rx_flush,
	input wire logic        u2_tx_flush,
	input wire logic [3:0]  u3_rx_threshold_sel,
	// uart3/4 clocking
	input wire logic        port3_midi_clock_sel,
	input wire logic        port4_midi_clock_sel,
	input wire logic        u3_high_speed,
	input wire logic        u4_high_speed,
	input wire logic        port3_midi_tick
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// ------
	// helpers
	// ------
	logic [15:0] gap;
	logic        armed;
	wire         in_win = config_index_register >= 8'h15 &&
		config_index_register <= 8'h19;
	wire         misc_wr = cfg_state && cfg_wr &&
		config_index_register == 8'h18;

	// armed only after a tick seen, first period phase is free
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n || !port3_midi_clock_sel || port3_midi_tick)
			gap <= 16'h0000;
		else
			gap <= gap + 16'h0001;
		armed <= rst_n && port3_midi_clock_sel && (armed || port3_midi_tick);
	end

	function automatic logic [3:0] lvl(input logic [1:0] c);
		return c[1] ? (c[0] ? 4'he : 4'h8) : (c[0] ? 4'h4 : 4'h1);
	endfunction

	sequence s_rx_req;
		u1_fcr_we && fcr_wdata[1];
	endsequence
	sequence s_tx_req;
		u2_fcr_we && fcr_wdata[2];
	endsequence

	// ------
	// properties
	// ------
	AST_U1_EN: assert property (u1_fcr_we |=>
		u1_fifo_enable == $past(fcr_wdata[0])) else $error("fifo enable");
	AST_U1_RXF: assert property (s_rx_req ##1 !u1_fcr_we |->
		u1_rx_flush ##1 !u1_rx_flush) else $error("rx flush pulse");
	AST_U2_TXF: assert property (s_tx_req ##1 !u2_fcr_we |->
		u2_tx_flush ##1 !u2_tx_flush) else $error("tx flush pulse");
	AST_U3_THR: assert property (u3_fcr_we |=>
		u3_rx_threshold_sel == lvl($past(fcr_wdata[7:6])))
		else $error("threshold decode");
	AST_MISC_WR: assert property (misc_wr &&
		!hard_reset |=> {u4_high_speed, u3_high_speed,
		port4_midi_clock_sel, port3_midi_clock_sel} ==
		$past(cfg_wdata[7:4])) else $error("misc write");
	AST_HARD_SPD: assert property (hard_reset |=>
		!u3_high_speed && !u4_high_speed) else $error("hard reset speed");
	AST_HARD_MIDI: assert property (hard_reset && !misc_wr |=>
		$stable({port4_midi_clock_sel, port3_midi_clock_sel}))
		else $error("hard reset midi");
	AST_RD_OUT: assert property (cfg_rd && !(cfg_state && in_win) |=>
		cfg_rdata == 8'h00) else $error("read outside window");
	AST_RD_MISC: assert property (cfg_state && cfg_rd &&
		!cfg_wr && !hard_reset && config_index_register == 8'h18 |=>
		cfg_rdata == {u4_high_speed, u3_high_speed, port4_midi_clock_sel,
		port3_midi_clock_sel, 4'h0}) else $error("misc readback");
	AST_HIT: assert property (cfg_hit == (cfg_state && in_win))
		else $error("index hit");
	AST_MIDI: assert property (armed |-> gap < MIDI_DIVISOR &&
		(!port3_midi_tick || gap == MIDI_DIVISOR - 16'h0001))
		else $error("midi tick period");
endmodule

bind ucsr_bank ucsr_bank_chk #(.MIDI_DIVISOR(MIDI_DIVISOR)) chk (.*);
